// ===== hdl/jie_pkg.sv
/*
 * shared constants and carrier types for the jump and increment execute block.
 * assumes a 14-bit instruction word, 8-bit data path, 13-bit program counter.
 */
package jie_pkg;

   localparam int INSN_W      = 14;
   localparam int DATA_W      = 8;
   localparam int PC_W        = 13;
   localparam int FADDR_W     = 7;
   localparam int LIT_W       = 11;

   // opcode field positions and patterns
   localparam int          JMP_OP_MSB   = 13;
   localparam int          JMP_OP_LSB   = 11;
   localparam logic [2:0]  JMP_OP       = 3'h5;
   localparam int          ALU_OP_MSB   = 13;
   localparam int          ALU_OP_LSB   = 8;
   localparam logic [5:0]  INC_OP       = 6'h0a;
   localparam logic [5:0]  INCSKIP_OP   = 6'h0f;
   localparam int          DEST_BIT     = 7;
   localparam int          LATCH_HI_BIT = 4;
   localparam int          LATCH_LO_BIT = 3;

   // reset values
   localparam logic [PC_W-1:0]   PC_RST   = 13'h0000;
   localparam logic [DATA_W-1:0] ACC_RST  = 8'h00;

   // instruction cycle counts
   localparam int JMP_CYCLES     = 2;
   localparam int SKIP_CYCLES    = 2;

   typedef struct packed {
      logic                 valid;
      logic [INSN_W-1:0]    word;
   } jie_insn_t;

   typedef struct packed {
      logic                 we;
      logic [FADDR_W-1:0]   addr;
      logic [DATA_W-1:0]    data;
   } jie_fwrite_t;

   typedef enum logic [2:0] {
      JIE_DEC_NONE    = 3'h1,
      JIE_DEC_JUMP    = 3'h2,
      JIE_DEC_INC     = 3'h4
   } jie_dec_t;

endpackage

// ===== hdl/jie_decode.sv
/*
 * combinational decoder for the jump and increment opcodes.
 * assumes an instruction word already latched by the caller.
 */
module jie_decode (
   input  wire logic [jie_pkg::INSN_W-1:0]  insn,
   output wire logic                        is_jump,
   output wire logic                        is_inc,
   output wire logic                        is_inc_skip,
   output wire logic                        dest_file,
   output wire logic [jie_pkg::FADDR_W-1:0] faddr,
   output wire logic [jie_pkg::LIT_W-1:0]   target
);

   // opcode field slices
   wire logic [2:0] top3 = insn[jie_pkg::JMP_OP_MSB:jie_pkg::JMP_OP_LSB];
   wire logic [5:0] top6 = insn[jie_pkg::ALU_OP_MSB:jie_pkg::ALU_OP_LSB];

   assign is_jump     = (top3 == jie_pkg::JMP_OP);
   assign is_inc      = (top6 == jie_pkg::INC_OP);
   assign is_inc_skip = (top6 == jie_pkg::INCSKIP_OP);
   assign dest_file   = insn[jie_pkg::DEST_BIT];
   assign faddr       = insn[jie_pkg::FADDR_W-1:0];
   assign target      = insn[jie_pkg::LIT_W-1:0];

endmodule

// ===== hdl/jie_exec.sv
/*
 * execute stage for absolute jump, increment and increment-skip-on-zero.
 * assumes the fetch stage presents one instruction per cycle in insn_in and
 * the register file returns fdata for faddr combinationally in that cycle.
 * assumes fetch honours flush by dropping the word it has already fetched,
 * and reloads from pc in the cycle that pc_load is high.
 * all other opcodes are one-cycle no-ops of this block; the rest of the
 * core decodes and executes them.
 * no clock enable: every flop here is clocked on the rising edge; pc, acc and zero_flag hold unless their load condition is set.
 */
module jie_exec (
   input  wire logic                          ref_clk,
   input  wire logic                          rst_b,
   input  wire jie_pkg::jie_insn_t            insn_in,
   input  wire logic [jie_pkg::DATA_W-1:0]    fdata,
   input  wire logic [jie_pkg::DATA_W-1:0]    program_counter_upper_latch,
   output logic [jie_pkg::FADDR_W-1:0]        faddr,
   output jie_pkg::jie_fwrite_t               fwrite,
   output logic [jie_pkg::DATA_W-1:0]         acc,
   output logic                               zero_flag,
   output logic [jie_pkg::PC_W-1:0]           pc,
   output logic                               pc_load,
   output logic                               flush,
   output logic                               busy
);

   typedef enum logic [1:0] {
      JIE_RUN   = 2'h1,
      JIE_BUBBLE = 2'h2
   } jie_state_t;

   jie_state_t state;
   jie_state_t next_state;

   // elaboration checks: one bubble state and fixed field slices serve
   // only this layout, so anything else is refused before it can run
   generate
      if (jie_pkg::JMP_CYCLES != 2) begin : g_chk_jmp_cycles
         $error("jie_exec: jump length other than two cycles not served");
      end

      if (jie_pkg::SKIP_CYCLES != 2) begin : g_chk_skip_cycles
         $error("jie_exec: skip length other than two cycles not served");
      end

      if (jie_pkg::PC_W != jie_pkg::LIT_W + 2) begin : g_chk_pc_width
         $error("jie_exec: counter must be literal plus two latch bits");
      end

      if (jie_pkg::LATCH_HI_BIT != jie_pkg::LATCH_LO_BIT + 1) begin : g_chk_latch_pair
         $error("jie_exec: latch bits must be adjacent");
      end

      if (jie_pkg::LATCH_HI_BIT >= jie_pkg::DATA_W) begin : g_chk_latch_range
         $error("jie_exec: latch bit outside the latch");
      end

      if (jie_pkg::DATA_W != 8) begin : g_chk_data_width
         $error("jie_exec: increment logic serves eight-bit data only");
      end

      if (jie_pkg::JMP_OP_MSB != jie_pkg::INSN_W - 1) begin : g_chk_jmp_top
         $error("jie_exec: jump opcode must sit at the top of the word");
      end

      if (jie_pkg::JMP_OP_MSB - jie_pkg::JMP_OP_LSB + 1 != 3) begin : g_chk_jmp_bits
         $error("jie_exec: jump opcode must be three bits");
      end

      if (jie_pkg::ALU_OP_MSB - jie_pkg::ALU_OP_LSB + 1 != 6) begin : g_chk_alu_bits
         $error("jie_exec: increment opcodes must be six bits");
      end

      if (jie_pkg::DEST_BIT != jie_pkg::FADDR_W) begin : g_chk_dest_bit
         $error("jie_exec: destination bit must sit just above the address");
      end

      if (jie_pkg::ALU_OP_LSB <= jie_pkg::DEST_BIT) begin : g_chk_alu_low
         $error("jie_exec: increment opcode overlaps the operand fields");
      end

      if (jie_pkg::LIT_W != jie_pkg::JMP_OP_LSB) begin : g_chk_lit_width
         $error("jie_exec: literal must fill the word below the jump opcode");
      end
   endgenerate

   wire logic                          dec_jump;
   wire logic                          dec_inc;
   wire logic                          dec_skip;
   wire logic                          dec_dest;
   wire logic [jie_pkg::FADDR_W-1:0]   dec_faddr;
   wire logic [jie_pkg::LIT_W-1:0]     dec_target;

   jie_decode u_dec (
      .insn        (insn_in.word),
      .is_jump     (dec_jump),
      .is_inc      (dec_inc),
      .is_inc_skip (dec_skip),
      .dest_file   (dec_dest),
      .faddr       (dec_faddr),
      .target      (dec_target)
   );

   // an instruction only executes in the run state; the bubble is the no-op
   wire logic run     = (state == JIE_RUN) && insn_in.valid;
   wire logic do_jump = run && dec_jump;
   wire logic do_inc  = run && (dec_inc || dec_skip);

   // no carry kept: these opcodes never report one
   // eight-bit wrap-around sum
   wire logic [jie_pkg::DATA_W-1:0] sum     = fdata + 8'h01;
   wire logic                       sum_zero = (sum == 8'h00);

   wire logic skip_take = run && dec_skip && sum_zero;

   wire logic [jie_pkg::PC_W-1:0] jump_pc = {program_counter_upper_latch[jie_pkg::LATCH_HI_BIT],
                                             program_counter_upper_latch[jie_pkg::LATCH_LO_BIT],
                                             dec_target};

   wire logic wr_file = do_inc && dec_dest;
   wire logic wr_acc  = do_inc && !dec_dest;

   // both jump and taken skip cost one bubble cycle
   always_comb begin
      next_state = state;
      unique case (state)
         JIE_RUN: begin
            if (do_jump || skip_take) begin
               next_state = JIE_BUBBLE;
            end
         end
         JIE_BUBBLE: begin
            next_state = JIE_RUN;
         end
         default: begin
            next_state = JIE_RUN;
         end
      endcase
   end

   // file address is combinational so the register file can answer now
   // the one output not from a flop, traded for a same-cycle read
   assign faddr = dec_faddr;

   // sequencing state
   // one bubble state: jump and taken skip both cost exactly one no-op
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= JIE_RUN;
      end else begin
         state <= next_state;
      end
   end

   // program counter load and flush pulses
   // pc only moves on a jump; sequential counting belongs to fetch
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         pc      <= jie_pkg::PC_RST;
         pc_load <= 1'b0;
         flush   <= 1'b0;
         busy    <= 1'b0;
      end else begin
         pc_load <= do_jump;
         flush   <= do_jump || skip_take;
         busy    <= (next_state == JIE_BUBBLE);
         if (do_jump) begin
            pc <= jump_pc;
         end
      end
   end

   // result writeback; jump and skip paths never touch the zero flag
   // write address and data load every cycle, only we qualifies them
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         acc       <= jie_pkg::ACC_RST;
         zero_flag <= 1'b0;
         fwrite    <= '0;
      end else begin
         fwrite.we   <= wr_file;
         fwrite.addr <= dec_faddr;
         fwrite.data <= sum;
         if (wr_acc) begin
            acc <= sum;
         end
         if (run && dec_inc) begin
            zero_flag <= sum_zero;
         end
      end
   end

endmodule

// ===== dv/jie_checker.sv
/* port checker for jie_exec.
   assumes one clock domain and the bind at the foot of this file. */
module jie_checker (
   input wire logic                        ref_clk,
   input wire logic                        rst_b,
   input wire jie_pkg::jie_insn_t          insn_in,
   input wire logic [7:0]                  fdata,
   input wire logic [7:0]                  program_counter_upper_latch,
   input wire logic [6:0]                  faddr,
   input wire jie_pkg::jie_fwrite_t        fwrite,
   input wire logic [7:0]                  acc,
   input wire logic                        zero_flag,
   input wire logic [12:0]                 pc,
   input wire logic                        pc_load,
   input wire logic                        flush,
   input wire logic                        busy
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   // accepted only outside the bubble
   wire logic        take = insn_in.valid && !busy;
   wire logic        is_j = take && insn_in.word[13:11] == 3'h5;
   wire logic        is_i = take && insn_in.word[13:8] == 6'h0a;
   wire logic        is_s = take && insn_in.word[13:8] == 6'h0f;
   wire logic        to_f = insn_in.word[7];
   wire logic [7:0]  sum  = fdata + 8'h01;
   wire logic [12:0] jt   = {program_counter_upper_latch[4:3], insn_in.word[10:0]};
   property p_jpc; is_j |=> pc == $past(jt) && pc_load && flush && busy; endproperty
   a_jpc: assert property (p_jpc) else $error("jump target wrong");
   property p_jz; is_j |=> $stable(zero_flag) ##1 !busy && !pc_load; endproperty
   a_jz: assert property (p_jz) else $error("jump flags or length wrong");
   property p_skip; is_s && sum == 8'h00 |=> flush && busy && $stable(zero_flag); endproperty
   a_skip: assert property (p_skip) else $error("skip not taken");
   property p_noskip; is_s && sum != 8'h00 |=> !flush && !busy && $stable(zero_flag); endproperty
   a_noskip: assert property (p_noskip) else $error("skip taken wrongly");
   property p_bub; busy |=> !busy; endproperty
   a_bub: assert property (p_bub) else $error("bubble longer than one");
   property p_z; is_i |=> zero_flag == ($past(sum) == 8'h00); endproperty
   a_z: assert property (p_z) else $error("zero flag wrong");
   property p_acc; (is_i || is_s) && !to_f |=> acc == $past(sum) && !fwrite.we; endproperty
   a_acc: assert property (p_acc) else $error("acc result wrong");
   property p_fw; (is_i || is_s) && to_f |=> fwrite.we && fwrite.data == $past(sum) && fwrite.addr == $past(faddr); endproperty
   a_fw: assert property (p_fw) else $error("file write wrong");
   property p_fa; insn_in.valid |-> faddr == insn_in.word[6:0]; endproperty
   a_fa: assert property (p_fa) else $error("file address wrong");
endmodule
bind jie_exec jie_checker jie_checker_i (.ref_clk(ref_clk), .rst_b(rst_b), .insn_in(insn_in), .fdata(fdata),
   .program_counter_upper_latch(program_counter_upper_latch), .faddr(faddr), .fwrite(fwrite), .acc(acc),
   .zero_flag(zero_flag), .pc(pc), .pc_load(pc_load), .flush(flush), .busy(busy));

// ===== dv/tb_top.sv
/* self-checking bench for jie_exec.
   assumes the checker is bound from its own file. */
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 0, rst_b = 0, pc_load, flush, busy, zero_flag;
   jie_pkg::jie_insn_t   insn_in = '0;
   jie_pkg::jie_fwrite_t fwrite;
   logic [7:0]  fdata = 8'h00, latch = 8'h00, acc;
   logic [6:0]  faddr;
   logic [12:0] pc;
   int failures = 0, cmp_count = 0;
   jie_exec jie_exec_i (.ref_clk(ref_clk), .rst_b(rst_b), .insn_in(insn_in), .fdata(fdata),
      .program_counter_upper_latch(latch), .faddr(faddr), .fwrite(fwrite), .acc(acc),
      .zero_flag(zero_flag), .pc(pc), .pc_load(pc_load), .flush(flush), .busy(busy));
   always #10 ref_clk = ~ref_clk;
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (e !== g) begin
         failures++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   // present one word at the falling edge, sample after the next rise
   task automatic step(input logic [13:0] w, input logic [7:0] d);
      @(negedge ref_clk);
      insn_in = '{1'b1, w};
      fdata = d;
      @(posedge ref_clk);
      #1;
   endtask
   task automatic idle();
      @(negedge ref_clk);
      insn_in.valid = 1'b0;
      @(posedge ref_clk);
      #1;
   endtask
   task automatic t_inc();
      step({6'h0a, 1'b0, 7'h11}, 8'hff);
      chk("acc", 8'h00, acc);
      chk("zero", 1'b1, zero_flag);
      step({6'h0a, 1'b1, 7'h22}, 8'h12);
      chk("fw", {1'b1, 7'h22, 8'h13}, fwrite);
      chk("zero", 1'b0, zero_flag);
      idle();
      chk("we", 1'b0, fwrite.we);
   endtask
   task automatic t_skip();
      step({6'h0f, 1'b1, 7'h33}, 8'hff);
      chk("fw", {1'b1, 7'h33, 8'h00}, fwrite);
      chk("flush", 2'h3, {flush, busy});
      chk("zero", 1'b0, zero_flag);
      step({6'h0a, 1'b0, 7'h01}, 8'h00);
      chk("acc", 8'h00, acc);
      step({6'h0f, 1'b0, 7'h44}, 8'h41);
      chk("acc", 8'h42, acc);
      chk("flush", 2'h0, {flush, busy});
      idle();
   endtask
   task automatic t_jump(input logic [7:0] l, input logic [10:0] k, input logic [12:0] e);
      @(negedge ref_clk);
      latch = l;
      step({3'h5, k}, 8'h00);
      chk("pc", e, pc);
      chk("pulses", 3'h7, {pc_load, flush, busy});
      step({6'h0a, 1'b0, 7'h02}, 8'h07);
      chk("acc", 8'h42, acc);
      chk("zero", 1'b0, zero_flag);
      idle();
      chk("pulses", 3'h0, {pc_load, flush, busy});
   endtask
   task automatic close_out();
      if (failures == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge ref_clk);
      chk("rst", 22'h0, {pc, acc, zero_flag});
      @(negedge ref_clk);
      rst_b = 1'b1;
      t_inc();
      t_skip();
      t_jump(8'h18, 11'h5a5, 13'h1da5);
      t_jump(8'he7, 11'h7ff, 13'h07ff);
      close_out();
   end
   // hang guard, far beyond the few dozen cycles used
   initial begin
      #100000;
      failures++;
      close_out();
   end
endmodule
